// >>> design/merge_pkg.sv
// constants and types for the merge-release arbiter with full-line priority override
package merge_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PRESET_W = 16;
  localparam int NLINE = 3;
  // line index: 0 left, 1 center, 2 right
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_BLK_L = 8'h04;
  localparam logic [ADDR_W-1:0] A_CLR_L = 8'h08;
  localparam logic [ADDR_W-1:0] A_BLK_R = 8'h0c;
  localparam logic [ADDR_W-1:0] A_CLR_R = 8'h10;
  localparam logic [ADDR_W-1:0] A_STAT = 8'h14;
  localparam logic [PRESET_W-1:0] PRESET_RST = 16'h1388;
  localparam int CLK_NS = 20;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;

  typedef enum logic [1:0] {
    PRI_FCFS = 2'b00,
    PRI_CENTER = 2'b01,
    PRI_LEFT = 2'b10,
    PRI_RIGHT = 2'b11
  } prio_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GRANT = 2'b01,
    ST_BUSY = 2'b10
  } arb_st_t;

  // control word, bit 0 is enable
  typedef struct packed {
    logic [1:0] mon_dn;
    logic [1:0] full_en;
    logic [1:0] tmerge;
    prio_t prio;
    logic [1:0] mtype;
    logic enable;
  } ctrl_t;

  localparam int CTRL_W = 11;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

  typedef struct packed {
    logic blocked;
    logic stopped;
  } zone_t;

  typedef logic [NLINE-1:0][NLINE-1:0] older_t;

  function automatic logic accumulated(input zone_t z);
    accumulated = z.blocked & z.stopped;
  endfunction

  // oldest member of set s; ties go to the lowest index
  function automatic logic [NLINE-1:0] pick_oldest(input logic [NLINE-1:0] s,
                                                   input older_t older);
    logic [NLINE-1:0] r;
    logic beaten;
    r = '0;
    for (int i = NLINE - 1; i >= 0; i--)
    begin
      beaten = 1'b0;
      for (int j = 0; j < NLINE; j++)
      begin
        if (j != i && s[j] && older[j][i])
        begin
          beaten = 1'b1;
        end
      end
      if (s[i] && !beaten)
      begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    pick_oldest = r;
  endfunction
endpackage

// >>> design/line_timer.sv
// block and clear timers of one monitored merging line
`timescale 1ns/1ps
module line_timer
  import merge_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // time base and settings
  input wire logic tick_i,
  input wire logic enable_i,
  input wire logic accum_i,
  input wire logic [PRESET_W-1:0] blk_preset_i,
  input wire logic [PRESET_W-1:0] clr_preset_i,
  // state
  output logic blk_expired_o,
  output logic dyn_o
);
  logic [PRESET_W-1:0] blk_q, blk_d, clr_q, clr_d;
  logic dyn_q, dyn_d;
  wire blk_done = blk_q >= blk_preset_i;
  wire clr_done = clr_q >= clr_preset_i;

  always_comb
  begin
    blk_d = blk_q;
    clr_d = clr_q;
    dyn_d = dyn_q;
    if (!accum_i)
      blk_d = '0;
    else if (tick_i && !dyn_q && !blk_done)
      blk_d = blk_q + 1'b1;
    if (dyn_q)
    begin
      if (clr_done)
      begin
        dyn_d = 1'b0;
        clr_d = '0;
        blk_d = '0;
      end
      else if (tick_i)
        clr_d = clr_q + 1'b1;
    end
    else if (enable_i && accum_i && blk_done)
      dyn_d = 1'b1;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      blk_q <= '0;
      clr_q <= '0;
      dyn_q <= 1'b0;
    end
    else
    begin
      blk_q <= blk_d;
      clr_q <= clr_d;
      dyn_q <= dyn_d;
    end
  end

  assign blk_expired_o = accum_i & blk_done;
  assign dyn_o = dyn_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_blk_zeroes: assert property (!accum_i |=> blk_q == '0)
    else $error("block timer not cleared");
  a_blk_counts: assert property (accum_i && tick_i && !dyn_q && !blk_done && accum_i
    |=> blk_q == $past(blk_q) + 1'b1 || !$past(accum_i))
    else $error("block timer did not count");
  a_dyn_starts: assert property (enable_i && accum_i && blk_done && !dyn_q |=> dyn_q)
    else $error("override not started");
  a_clr_ends: assert property (dyn_q && clr_done |=> !dyn_q && clr_q == '0)
    else $error("override outlived clear time");
endmodule

// >>> design/merge_dynamic_priority.sv
// merge-release arbiter with full-line priority override
`timescale 1ns/1ps
module merge_dynamic_priority
  import merge_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // zone status, line index 0 left, 1 center, 2 right; monitor zone index 0 left, 1 right
  input wire logic [NLINE-1:0] arrive_i,
  input wire logic merge_clear_i,
  input wire zone_t [1:0] mon_up_i,
  input wire zone_t [1:0] mon_dn_i,
  // release and status
  output logic [NLINE-1:0] release_o,
  output logic [1:0] tmerge_o,
  output logic [1:0] dyn_o
);
  ctrl_t ctrl_q;
  logic [PRESET_W-1:0] blk_pre_q [2];
  logic [PRESET_W-1:0] clr_pre_q [2];
  logic [15:0] tick_cnt_q;
  logic tick_q;
  logic [NLINE-1:0] arr_q, grant_q, grant_d;
  older_t older_q, older_d;
  arb_st_t st_q, st_d;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0] dyn, blk_exp, accum;

  // time base: one tick per millisecond of preset
  wire tick_wrap = tick_cnt_q == 16'(TICK_CYC - 1);
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tick_wrap ? 16'h0000 : tick_cnt_q + 16'h0001;
      tick_q <= tick_wrap;
    end
  end

  // register writes
  wire wr_ctrl = wr_i && addr_i == A_CTRL;
  wire [1:0] wr_blk = {wr_i && addr_i == A_BLK_R, wr_i && addr_i == A_BLK_L};
  wire [1:0] wr_clr = {wr_i && addr_i == A_CLR_R, wr_i && addr_i == A_CLR_L};
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ctrl_q <= ctrl_t'(CTRL_RST);
    else if (wr_ctrl)
      ctrl_q <= ctrl_t'(wdata_i[CTRL_W-1:0]);
  end
  for (genvar k = 0; k < 2; k++)
  begin : g_pre
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
      if (!arst_n_i)
      begin
        blk_pre_q[k] <= PRESET_RST;
        clr_pre_q[k] <= PRESET_RST;
      end
      else
      begin
        if (wr_blk[k])
          blk_pre_q[k] <= wdata_i[PRESET_W-1:0];
        if (wr_clr[k])
          clr_pre_q[k] <= wdata_i[PRESET_W-1:0];
      end
    end
    // chosen zone of the identified controller feeds the timers
    assign accum[k] = ctrl_q.mon_dn[k] ? accumulated(mon_dn_i[k])
                                       : accumulated(mon_up_i[k]);
  end

  line_timer u_tmr_l (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .tick_i(tick_q),
    .enable_i(ctrl_q.full_en[0] & ctrl_q.mtype[0]),
    .accum_i(accum[0]),
    .blk_preset_i(blk_pre_q[0]),
    .clr_preset_i(clr_pre_q[0]),
    .blk_expired_o(blk_exp[0]),
    .dyn_o(dyn[0])
  );
  line_timer u_tmr_r (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .tick_i(tick_q),
    .enable_i(ctrl_q.full_en[1] & ctrl_q.mtype[1]),
    .accum_i(accum[1]),
    .blk_preset_i(blk_pre_q[1]),
    .clr_preset_i(clr_pre_q[1]),
    .blk_expired_o(blk_exp[1]),
    .dyn_o(dyn[1])
  );

  // lines in use, center always when merging is on
  wire [NLINE-1:0] line_en = {ctrl_q.mtype[1], 1'b1, ctrl_q.mtype[0]} & {NLINE{ctrl_q.enable}};
  wire [NLINE-1:0] arr = arrive_i & line_en;
  wire [NLINE-1:0] base_fav = ctrl_q.prio == PRI_CENTER ? 3'b010 :
                              ctrl_q.prio == PRI_LEFT ? 3'b001 :
                              ctrl_q.prio == PRI_RIGHT ? 3'b100 : 3'b000;
  // override replaces the base favourite; two overrides share it by arrival
  wire [NLINE-1:0] fav = |dyn ? {dyn[1], 1'b0, dyn[0]} : base_fav;
  wire [NLINE-1:0] cand = |(arr & fav) ? arr & fav : arr;
  // rank by next order, so a line arriving this cycle queues behind waiting ones
  wire [NLINE-1:0] choice = pick_oldest(cand, older_d);

  // arrival order: a new arrival is younger than everything already waiting
  always_comb
  begin
    older_d = older_q;
    for (int i = 0; i < NLINE; i++)
    begin
      if (arr[i] && !arr_q[i])
      begin
        for (int j = 0; j < NLINE; j++)
        begin
          older_d[j][i] = arr_q[j] && j != i;
          older_d[i][j] = 1'b0;
        end
      end
    end
  end

  // one release at a time; next only after the merge zone has cleared
  always_comb
  begin
    st_d = st_q;
    grant_d = grant_q;
    unique case (st_q)
      ST_IDLE:
        if (merge_clear_i && |arr)
        begin
          grant_d = choice;
          st_d = ST_GRANT;
        end
      ST_GRANT:
        if (!merge_clear_i)
        begin
          grant_d = '0;
          st_d = ST_BUSY;
        end
      ST_BUSY:
        if (merge_clear_i)
          st_d = ST_IDLE;
      default:
      begin
        grant_d = '0;
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_q <= ST_IDLE;
      grant_q <= '0;
      arr_q <= '0;
      older_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      grant_q <= grant_d;
      arr_q <= arr;
      older_q <= older_d;
    end
  end

  // read data stands only in the cycle after the read strobe
  wire [DATA_W-1:0] stat = {21'h0, dyn, blk_exp, grant_q, 2'(st_q), ctrl_q.enable, 1'b0};
  wire [DATA_W-1:0] rd_mux = addr_i == A_CTRL ? {21'h0, ctrl_q} :
                             addr_i == A_BLK_L ? {16'h0000, blk_pre_q[0]} :
                             addr_i == A_CLR_L ? {16'h0000, clr_pre_q[0]} :
                             addr_i == A_BLK_R ? {16'h0000, blk_pre_q[1]} :
                             addr_i == A_CLR_R ? {16'h0000, clr_pre_q[1]} :
                             addr_i == A_STAT ? stat : 32'h00000000;
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_q <= '0;
    else
      rdata_q <= rd_i ? rd_mux : 32'h00000000;
  end

  assign rdata_o = rdata_q;
  assign release_o = grant_q;
  assign tmerge_o = ctrl_q.tmerge;
  assign dyn_o = dyn;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_idle_req;
    st_q == ST_IDLE && merge_clear_i && |arr;
  endsequence
  sequence s_zone_taken;
    st_q == ST_GRANT && !merge_clear_i;
  endsequence

  a_single_release: assert property ($onehot0(grant_q))
    else $error("more than one line released");
  a_grant_on_clear: assert property (s_idle_req |=> grant_q != '0 && st_q == ST_GRANT)
    else $error("waiting product not released");
  a_hold_off_busy: assert property (s_zone_taken |=> grant_q == '0 ##1 grant_q == '0)
    else $error("release while merge zone occupied");
  a_fav_center: assert property (s_idle_req and (dyn == 2'b00 && ctrl_q.prio == PRI_CENTER
    && arr[1]) |=> grant_q == 3'b010)
    else $error("favoured center lost the zone");
  a_starve_left: assert property (s_idle_req and (dyn == 2'b00 && ctrl_q.prio == PRI_CENTER
    && arr[1]) |=> !grant_q[0])
    else $error("left released against base priority");
  a_override_left: assert property (s_idle_req and (dyn == 2'b01 && arr[0])
    |=> grant_q == 3'b001)
    else $error("overriding line not favoured");
  a_both_fcfs: assert property (s_idle_req and (dyn == 2'b11 && arr[0] && arr[2]
    && older_d[2][0]) |=> grant_q == 3'b100)
    else $error("older overriding line not first");
  a_ctrl_write: assert property (wr_ctrl |=> tmerge_o == $past(wdata_i[6:5]))
    else $error("throw-across flags not stored");
endmodule

// >>> bench/zone_model.sv
// zone controller model: arrivals, merge zone occupancy, monitor zones
`timescale 1ns/1ps
module zone_model
  import merge_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // commands from the arbiter and the bench
  input wire logic [NLINE-1:0] release_i,
  input wire logic [NLINE-1:0] want_i,
  input wire logic [3:0] accum_i,
  input wire logic slow_i,
  // zone status
  output logic [NLINE-1:0] arrive_o,
  output logic merge_clear_o,
  output zone_t [1:0] mon_up_o,
  output zone_t [1:0] mon_dn_o
);
  int occ;
  logic tog;

  // held want means a steady product flow on that line
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      arrive_o <= '0;
      occ <= 0;
      tog <= 1'b0;
    end
    else
    begin
      tog <= ~tog;
      arrive_o <= want_i & ~release_i;
      if (|release_i)
        occ <= slow_i ? 12 : 4;
      else if (occ > 0)
        occ <= occ - 1;
    end
  end

  assign merge_clear_o = (occ == 0);

  // idle monitor zones toggle blocked so a stale level is never mistaken for accumulation
  for (genvar i = 0; i < 2; i++)
  begin : g_mon
    assign mon_up_o[i] = accum_i[i] ? 2'b11 : {tog, 1'b0};
    assign mon_dn_o[i] = accum_i[i + 2] ? 2'b11 : {~tog, 1'b0};
  end
endmodule

// >>> bench/tb_top.sv
// self-checking bench for the merge arbiter
`timescale 1ns/1ps
module tb_top;
  import merge_pkg::*;
  localparam int TC = 4;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [DATA_W-1:0] rdata_o, rv;
  logic [NLINE-1:0] arrive_i, release_o, g;
  logic [NLINE-1:0] want = '0;
  logic merge_clear_i;
  zone_t [1:0] mon_up_i, mon_dn_i;
  logic [1:0] tmerge_o, dyn_o;
  logic [3:0] accum = '0;
  logic slow = 1'b0;
  ctrl_t c;
  int failures = 0;
  int tests_run = 0;
  int n;
  int hi;

  initial
  begin
    forever #(CLK_NS / 2) clk_i = ~clk_i;
  end

  merge_dynamic_priority #(.TICK_CYC(TC)) uut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .arrive_i(arrive_i),
    .merge_clear_i(merge_clear_i), .mon_up_i(mon_up_i), .mon_dn_i(mon_dn_i),
    .release_o(release_o), .tmerge_o(tmerge_o), .dyn_o(dyn_o));

  zone_model u_zone (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .release_i(release_o), .want_i(want),
    .accum_i(accum), .slow_i(slow), .arrive_o(arrive_i), .merge_clear_o(merge_clear_i),
    .mon_up_o(mon_up_i), .mon_dn_o(mon_dn_i));

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask

  task automatic setc(input prio_t p, input logic [1:0] m, f, d, t);
    c = '{mon_dn: d, full_en: f, tmerge: t, prio: p, mtype: m, enable: 1'b1};
    wr(A_CTRL, 32'(c));
  endtask

  // skips a grant already standing, then waits for the next one
  task automatic wait_rel(output logic [NLINE-1:0] r);
    @(negedge clk_i);
    for (int i = 0; i < 400 && release_o !== '0; i++)
      @(negedge clk_i);
    r = '0;
    for (int i = 0; i < 400 && r == '0; i++)
    begin
      @(negedge clk_i);
      r = release_o;
    end
    @(posedge clk_i);
  endtask

  task automatic wait_dyn(input int b, input logic v, output int k);
    k = 0;
    while (dyn_o[b] !== v && k < 400)
    begin
      @(negedge clk_i);
      k++;
    end
    if (k >= 400)
      failures++;
    @(posedge clk_i);
  endtask

  task automatic watch(input int cyc);
    repeat (cyc)
    begin
      @(negedge clk_i);
      hi += int'(dyn_o[0] !== 1'b0);
    end
    @(posedge clk_i);
  endtask

  function automatic logic [NLINE-1:0] exp_grant(input logic [NLINE-1:0] a, input ctrl_t k);
    logic [NLINE-1:0] e;
    e = a & {k.mtype[1], 1'b1, k.mtype[0]};
    case (k.prio)
      PRI_CENTER: if (e[1]) return 3'b010;
      PRI_LEFT: if (e[0]) return 3'b001;
      PRI_RIGHT: if (e[2]) return 3'b100;
      default: ;
    endcase
    return e & -e;
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #(CLK_NS * 60000);
    failures++;
    finish_test();
  end

  initial
  begin
    void'($urandom(75));
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      rd(ADDR_W'(4 * i), rv);
      check(rv, (i == 0 || i >= 5) ? 32'h0 : 32'(PRESET_RST));
    end
    wr(A_BLK_L, 32'h5a5a0003);
    wr(8'h18, 32'hffffffff);
    wr(A_CLR_L, 32'h6);
    rd(A_BLK_L, rv);
    check(rv, 32'h3);
    rd(8'h18, rv);
    check(rv, 32'h0);
    setc(PRI_FCFS, 2'b11, 2'b00, 2'b00, 2'b10);
    @(posedge clk_i);
    check(32'(tmerge_o), 32'h2);
    $display("done: registers");
    // long occupancy lets right queue before left
    slow <= 1'b1;
    want <= 3'b010;
    wait_rel(g);
    want <= 3'b100;
    repeat (2) @(posedge clk_i);
    want <= 3'b101;
    wait_rel(g);
    check(32'(g), 32'h4);
    wait_rel(g);
    check(32'(g), 32'h1);
    want <= '0;
    slow <= 1'b0;
    $display("done: first come");
    setc(PRI_CENTER, 2'b01, 2'b01, 2'b00, 2'b00);
    want <= 3'b011;
    repeat (4)
    begin
      wait_rel(g);
      check(32'(g), 32'h2);
    end
    @(posedge clk_i);
    accum <= 4'h1;
    wait_dyn(0, 1'b1, n);
    check(32'(n >= 2 * TC && n <= 4 * TC + 4), 32'h1);
    wait_rel(g);
    check(32'(g), 32'h1);
    accum <= 4'h0;
    wait_dyn(0, 1'b0, n);
    check(32'(n <= 7 * TC + 4), 32'h1);
    wait_rel(g);
    check(32'(g), 32'h2);
    want <= '0;
    $display("done: override");
    wr(A_BLK_L, 32'h6);
    setc(PRI_CENTER, 2'b01, 2'b01, 2'b01, 2'b00);
    @(posedge clk_i);
    accum <= 4'h1;
    hi = 0;
    watch(40);
    check(32'(hi), 32'h0);
    for (int k = 0; k < 3; k++)
    begin
      accum <= 4'h4;
      watch(14);
      accum <= 4'h0;
      watch(4);
    end
    check(32'(hi), 32'h0);
    accum <= 4'h4;
    wait_dyn(0, 1'b1, n);
    check(32'(n >= 5 * TC && n <= 7 * TC + 4), 32'h1);
    accum <= 4'h0;
    wait_dyn(0, 1'b0, n);
    $display("done: monitor zone");
    wr(A_BLK_L, 32'h1);
    wr(A_BLK_R, 32'h1);
    wr(A_CLR_L, 32'h32);
    wr(A_CLR_R, 32'h32);
    setc(PRI_CENTER, 2'b11, 2'b11, 2'b00, 2'b00);
    accum <= 4'h3;
    wait_dyn(1, 1'b1, n);
    check(32'(dyn_o), 32'h3);
    want <= 3'b111;
    wait_rel(g);
    check(32'(g), 32'h1);
    wait_rel(g);
    check(32'(g), 32'h4);
    want <= '0;
    accum <= 4'h0;
    wait_dyn(0, 1'b0, n);
    wait_dyn(1, 1'b0, n);
    $display("done: two overrides");
    for (int k = 0; k < 30; k++)
    begin
      setc(prio_t'($urandom_range(3)), 2'($urandom_range(3, 1)), 2'b00, 2'b00, 2'($urandom));
      g = 3'($urandom_range(7, 1));
      want <= g;
      wait_rel(rv[2:0]);
      want <= '0;
      check(32'(rv[2:0]), 32'(exp_grant(g, c)));
      check(32'(tmerge_o), 32'(c.tmerge));
    end
    $display("done: random");
    finish_test();
  end
endmodule
